// File: hdl/ptp_rew_pkg.sv
// constants, register map and types for the timing action decoder
package ptp_rew_pkg;
  localparam int NPORTS = 11;
  localparam logic [3:0] PORT_CPU = 4'hB;
  localparam logic [3:0] PORT_VD = 4'hC;
  localparam int ADDR_W = 12;
  localparam int SEQ_DEPTH = 256;
  localparam int SEQ_W = 16;
  localparam int FIFO_DEPTH = 1024;
  localparam int PTR_W = 11;
  localparam int STAMP_W = 32;
  localparam int ENTRY_W = 37;
  localparam logic [PTR_W-1:0] FIFO_FULL_CNT = 11'h400;
  // per-port register regions, one word per port
  localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_EDLY = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_IDLY1 = 12'h080;
  localparam logic [ADDR_W-1:0] OFS_IDLY2 = 12'h0C0;
  localparam logic [ADDR_W-1:0] OFS_SMAC_LO = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_SMAC_HI = 12'h140;
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG = 12'h180;
  // single registers, then the base of the sequence table
  localparam logic [ADDR_W-1:0] OFS_CSUM_DIS = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_CPU_MODE = 12'h204;
  localparam logic [ADDR_W-1:0] OFS_RSRV = 12'h208;
  localparam logic [ADDR_W-1:0] OFS_EVENTS = 12'h20C;
  localparam logic [ADDR_W-1:0] OFS_PHY_PRED0 = 12'h210;
  localparam logic [ADDR_W-1:0] OFS_PHY_PRED1 = 12'h214;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 12'h218;
  localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 12'h21C;
  localparam logic [ADDR_W-1:0] OFS_FIFO_ENTRY = 12'h220;
  localparam logic [ADDR_W-1:0] OFS_SEQ = 12'h400;
  // action word fields
  localparam int ACT_TS_LSB = 0;
  localparam int ACT_DLY_LSB = 2;
  localparam int ACT_SEQ_LSB = 4;
  localparam int ACT_S2D_BIT = 6;
  localparam int ACT_CFG_SMAC_BIT = 7;
  localparam logic [1:0] TS_NOP = 2'h0;
  localparam logic [1:0] TS_ONE = 2'h1;
  localparam logic [1:0] TS_TWO = 2'h2;
  localparam logic [1:0] TS_TOD = 2'h3;
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_EGR = 2'h1;
  localparam logic [1:0] DLY_ING1 = 2'h2;
  localparam logic [1:0] DLY_ING2 = 2'h3;
  localparam logic [1:0] SEQ_NOP = 2'h0;
  localparam logic [1:0] SEQ_UPD = 2'h1;
  // register field positions
  localparam int MODE_DOM_LSB = 0;
  localparam int MODE_MODE_LSB = 2;
  localparam int CPU_VD_LSB = 4;
  localparam int PCFG_EN_BIT = 16;
  localparam int PCFG_DOM_LSB = 17;
  localparam int CTRL_POP_BIT = 0;
  localparam int CTRL_PORT_LSB = 12;
  localparam int CTRL_EGR_BIT = 16;
  localparam int CTRL_VALID_BIT = 17;
  localparam int CTRL_OVF_BIT = 18;
  localparam logic [1:0] DOM_RESET = 2'h0;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PUSH_INGRESS = 2'b01} state_e;
endpackage

// File: hdl/ptp_rewriter_action_decode.sv
// timing action decoder, per-port timing configuration, sequence table and stamp fifo
// Summary of operation
// - bits 1-0 select timing operation
// - bits 3-2 select delay to add
// - bits 5-4 sequence or delay-request command
// - 256-entry sequence table indexed by stamp
// - put entry into frame, then increment
// - delay-request one-step flags reception-time correction
// - bit 6 copies source into destination
// - bit 7 substitutes configured source address
// - per-port domain and timing mode
// - separate cpu and virtual-device mode
// - egress and two ingress delays per port
// - substitute address split low and high
// - per-port checksum update disable
// - control write advances fifo, entry readable
// - sticky bit for non-zero reserved bytes
// - software reads and writes sequence entries
// - port io delay, enable, domain
// - sticky correction overflow event per port
// - per-port clock phase evaluation enable
// - fifo of 1024 stamp entries
// - two-step pushes egress then ingress entry
// - three domains, all default zero
`timescale 1ns/1ps
`default_nettype none
module ptp_rewriter_action_decode (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [ptp_rew_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // frame in from the classifier
  input wire logic i_frm_valid,
  output logic o_frm_ready,
  input wire logic [7:0] i_frm_action,
  input wire logic [ptp_rew_pkg::STAMP_W-1:0] i_frm_tstamp,
  input wire logic [ptp_rew_pkg::STAMP_W-1:0] i_frm_egress_stamp,
  input wire logic [3:0] i_frm_rx_port,
  input wire logic [3:0] i_frm_tx_port,
  input wire logic [47:0] i_frm_smac,
  input wire logic [47:0] i_frm_dmac,
  input wire logic i_frm_rsrv_nonzero,
  // frame out to the port module
  output logic o_out_valid,
  output logic [3:0] o_out_tx_port,
  output logic [1:0] o_out_ts_mode,
  output logic [31:0] o_out_delay,
  output logic o_out_cf_rx_time,
  output logic o_out_seq_valid,
  output logic [ptp_rew_pkg::SEQ_W-1:0] o_out_seq_no,
  output logic [47:0] o_out_dmac,
  output logic [47:0] o_out_smac,
  output logic o_out_csum_update,
  output logic [1:0] o_out_domain,
  output logic [1:0] o_out_port_mode,
  // port module configuration and events
  input wire logic [ptp_rew_pkg::NPORTS-1:0] i_cf_overflow,
  output logic [ptp_rew_pkg::NPORTS-1:0][15:0] o_port_io_delay,
  output logic [ptp_rew_pkg::NPORTS-1:0] o_port_ptp_en,
  output logic [ptp_rew_pkg::NPORTS-1:0][1:0] o_port_domain,
  output logic [1:0][15:0] o_phy_predict,
  output logic [ptp_rew_pkg::NPORTS-1:0] o_phase_predict_en
);
  localparam int N = ptp_rew_pkg::NPORTS;

  typedef struct packed {
    ptp_rew_pkg::state_e state;
    logic ready;
    logic [N-1:0][1:0] domain;
    logic [N-1:0][1:0] pmode;
    logic [N-1:0][31:0] edly;
    logic [N-1:0][31:0] idly1;
    logic [N-1:0][31:0] idly2;
    logic [N-1:0][31:0] smac_lo;
    logic [N-1:0][15:0] smac_hi;
    logic [N-1:0] csum_dis;
    logic [1:0][1:0] cpu_dom;
    logic [1:0][1:0] cpu_mode;
    logic [N-1:0] rsrv_sticky;
    logic [N-1:0] ovf_sticky;
    logic [N-1:0][15:0] io_dly;
    logic [N-1:0] ptp_en;
    logic [N-1:0][1:0] port_dom;
    logic [1:0][15:0] phy_pred;
    logic [N-1:0] phase_en;
    logic [ptp_rew_pkg::PTR_W-1:0] wptr;
    logic [ptp_rew_pkg::PTR_W-1:0] rptr;
    logic fifo_ovf;
    logic [3:0] pend_port;
    logic [ptp_rew_pkg::STAMP_W-1:0] pend_stamp;
    logic [31:0] rdata;
    logic out_valid;
    logic [3:0] out_tx_port;
    logic [1:0] out_ts_mode;
    logic [31:0] out_delay;
    logic out_cf_rx_time;
    logic out_seq_valid;
    logic [ptp_rew_pkg::SEQ_W-1:0] out_seq_no;
    logic [47:0] out_dmac;
    logic [47:0] out_smac;
    logic out_csum_update;
    logic [1:0] out_domain;
    logic [1:0] out_port_mode;
  } regs_s;

  regs_s r;
  regs_s next_r;

  // storage too large for the state struct; no reset needed on data words
  logic [ptp_rew_pkg::SEQ_W-1:0] seq_table [ptp_rew_pkg::SEQ_DEPTH];
  logic [ptp_rew_pkg::ENTRY_W-1:0] fifo_mem [ptp_rew_pkg::FIFO_DEPTH];

  logic seq_we;
  logic [7:0] seq_widx;
  logic [ptp_rew_pkg::SEQ_W-1:0] seq_wdata;
  logic fifo_we;
  logic [ptp_rew_pkg::ENTRY_W-1:0] fifo_wdata;

  // true when addr falls in a per-port region and names an existing port
  function automatic logic port_hit(input logic [ptp_rew_pkg::ADDR_W-1:0] addr,
                                    input logic [ptp_rew_pkg::ADDR_W-1:0] base);
    port_hit = (addr[ptp_rew_pkg::ADDR_W-1:6] == base[ptp_rew_pkg::ADDR_W-1:6]) &&
               (addr[1:0] == 2'h0) && (addr[5:2] < ptp_rew_pkg::PORT_CPU);
  endfunction

  function automatic logic [3:0] port_of(input logic [ptp_rew_pkg::ADDR_W-1:0] addr);
    port_of = addr[5:2];
  endfunction

  always_comb begin
    logic [1:0] ts_cmd;
    logic [1:0] dly_cmd;
    logic [1:0] seq_cmd;
    logic take;
    logic tx_front;
    logic rx_front;
    logic [3:0] pi;
    logic [ptp_rew_pkg::PTR_W-1:0] count;
    logic pop;
    logic [N-1:0] wmask;
    logic [ptp_rew_pkg::ENTRY_W-1:0] head;
    next_r = r;
    ts_cmd = i_frm_action[ptp_rew_pkg::ACT_TS_LSB +: 2];
    dly_cmd = i_frm_action[ptp_rew_pkg::ACT_DLY_LSB +: 2];
    seq_cmd = i_frm_action[ptp_rew_pkg::ACT_SEQ_LSB +: 2];
    take = i_frm_valid && r.ready;
    tx_front = i_frm_tx_port < ptp_rew_pkg::PORT_CPU;
    rx_front = i_frm_rx_port < ptp_rew_pkg::PORT_CPU;
    pi = port_of(i_reg_addr);
    count = r.wptr - r.rptr;
    head = (count != '0) ? fifo_mem[r.rptr[ptp_rew_pkg::PTR_W-2:0]] : '0;
    pop = 1'b0;
    wmask = '0;
    seq_we = 1'b0;
    seq_widx = i_reg_addr[9:2];
    seq_wdata = i_reg_wdata[ptp_rew_pkg::SEQ_W-1:0];
    fifo_we = 1'b0;
    fifo_wdata = {1'b1, i_frm_tx_port, i_frm_egress_stamp};

    // frame path: every field of the output is settled in the cycle the frame is taken
    next_r.out_valid = take;
    if (take) begin
      next_r.out_tx_port = i_frm_tx_port;
      next_r.out_ts_mode = ts_cmd;
      case (dly_cmd)
        ptp_rew_pkg::DLY_EGR: next_r.out_delay = tx_front ? r.edly[i_frm_tx_port] : 32'h0;
        ptp_rew_pkg::DLY_ING1: next_r.out_delay = rx_front ? r.idly1[i_frm_rx_port] : 32'h0;
        ptp_rew_pkg::DLY_ING2: next_r.out_delay = rx_front ? r.idly2[i_frm_rx_port] : 32'h0;
        default: next_r.out_delay = 32'h0;
      endcase
      // the analyzer builds the response; here only the correction source changes
      next_r.out_cf_rx_time = seq_cmd[1] && (ts_cmd == ptp_rew_pkg::TS_ONE);
      next_r.out_seq_valid = seq_cmd == ptp_rew_pkg::SEQ_UPD;
      next_r.out_seq_no = seq_table[i_frm_tstamp[7:0]];
      next_r.out_dmac = i_frm_action[ptp_rew_pkg::ACT_S2D_BIT] ? i_frm_smac : i_frm_dmac;
      next_r.out_smac = i_frm_smac;
      if (i_frm_action[ptp_rew_pkg::ACT_CFG_SMAC_BIT] && tx_front) begin
        next_r.out_smac = {r.smac_hi[i_frm_tx_port], r.smac_lo[i_frm_tx_port]};
      end
      next_r.out_csum_update = !(tx_front && r.csum_dis[i_frm_tx_port]);
      if (tx_front) begin
        next_r.out_domain = r.domain[i_frm_tx_port];
        next_r.out_port_mode = r.pmode[i_frm_tx_port];
      end else if (i_frm_tx_port == ptp_rew_pkg::PORT_CPU || i_frm_tx_port == ptp_rew_pkg::PORT_VD) begin
        next_r.out_domain = r.cpu_dom[i_frm_tx_port == ptp_rew_pkg::PORT_VD];
        next_r.out_port_mode = r.cpu_mode[i_frm_tx_port == ptp_rew_pkg::PORT_VD];
      end else begin
        next_r.out_domain = ptp_rew_pkg::DOM_RESET;
        next_r.out_port_mode = 2'h0;
      end
    end

    // frame bumps the sequence entry; it wins over a software write in the same cycle
    if (take && seq_cmd == ptp_rew_pkg::SEQ_UPD) begin
      seq_we = 1'b1;
      seq_widx = i_frm_tstamp[7:0];
      seq_wdata = seq_table[i_frm_tstamp[7:0]] + 16'h1;
    end else if (i_reg_wr && i_reg_addr[10] && i_reg_addr[1:0] == 2'h0) begin
      seq_we = 1'b1;
    end

    // two-step: egress entry now, ingress entry next cycle; frames stall meanwhile
    case (r.state)
      ptp_rew_pkg::ST_IDLE: begin
        if (take && ts_cmd == ptp_rew_pkg::TS_TWO) begin
          fifo_we = 1'b1;
          next_r.pend_port = i_frm_rx_port;
          next_r.pend_stamp = i_frm_tstamp;
          next_r.state = ptp_rew_pkg::ST_PUSH_INGRESS;
        end
      end
      ptp_rew_pkg::ST_PUSH_INGRESS: begin
        fifo_we = 1'b1;
        fifo_wdata = {1'b0, r.pend_port, r.pend_stamp};
        next_r.state = ptp_rew_pkg::ST_IDLE;
      end
      default: next_r.state = ptp_rew_pkg::ST_IDLE;
    endcase
    next_r.ready = next_r.state == ptp_rew_pkg::ST_IDLE;

    // register writes
    if (i_reg_wr) begin
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_MODE)) begin
        next_r.domain[pi] = i_reg_wdata[ptp_rew_pkg::MODE_DOM_LSB +: 2];
        next_r.pmode[pi] = i_reg_wdata[ptp_rew_pkg::MODE_MODE_LSB +: 2];
      end
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_EDLY)) next_r.edly[pi] = i_reg_wdata;
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_IDLY1)) next_r.idly1[pi] = i_reg_wdata;
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_IDLY2)) next_r.idly2[pi] = i_reg_wdata;
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_SMAC_LO)) next_r.smac_lo[pi] = i_reg_wdata;
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_SMAC_HI)) next_r.smac_hi[pi] = i_reg_wdata[15:0];
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_PORT_CFG)) begin
        next_r.io_dly[pi] = i_reg_wdata[15:0];
        next_r.ptp_en[pi] = i_reg_wdata[ptp_rew_pkg::PCFG_EN_BIT];
        next_r.port_dom[pi] = i_reg_wdata[ptp_rew_pkg::PCFG_DOM_LSB +: 2];
      end
      case (i_reg_addr)
        ptp_rew_pkg::OFS_CSUM_DIS: next_r.csum_dis = i_reg_wdata[N-1:0];
        ptp_rew_pkg::OFS_CPU_MODE: begin
          next_r.cpu_dom[0] = i_reg_wdata[ptp_rew_pkg::MODE_DOM_LSB +: 2];
          next_r.cpu_mode[0] = i_reg_wdata[ptp_rew_pkg::MODE_MODE_LSB +: 2];
          next_r.cpu_dom[1] = i_reg_wdata[ptp_rew_pkg::CPU_VD_LSB + ptp_rew_pkg::MODE_DOM_LSB +: 2];
          next_r.cpu_mode[1] = i_reg_wdata[ptp_rew_pkg::CPU_VD_LSB + ptp_rew_pkg::MODE_MODE_LSB +: 2];
        end
        ptp_rew_pkg::OFS_RSRV: wmask = i_reg_wdata[N-1:0];
        ptp_rew_pkg::OFS_PHY_PRED0: next_r.phy_pred[0] = i_reg_wdata[15:0];
        ptp_rew_pkg::OFS_PHY_PRED1: next_r.phy_pred[1] = i_reg_wdata[15:0];
        ptp_rew_pkg::OFS_PHASE: next_r.phase_en = i_reg_wdata[N-1:0];
        ptp_rew_pkg::OFS_FIFO_CTRL: begin
          pop = i_reg_wdata[ptp_rew_pkg::CTRL_POP_BIT] && count != '0;
          if (i_reg_wdata[ptp_rew_pkg::CTRL_OVF_BIT]) next_r.fifo_ovf = 1'b0;
        end
        default: ;
      endcase
    end

    // sticky bits: write-one clears, a set in the same cycle wins
    next_r.rsrv_sticky = r.rsrv_sticky & ~wmask;
    if (take && i_frm_rsrv_nonzero && rx_front) next_r.rsrv_sticky[i_frm_rx_port] = 1'b1;
    next_r.ovf_sticky = r.ovf_sticky | i_cf_overflow;
    if (i_reg_wr && i_reg_addr == ptp_rew_pkg::OFS_EVENTS) begin
      next_r.ovf_sticky = (r.ovf_sticky & ~i_reg_wdata[N-1:0]) | i_cf_overflow;
    end

    // fifo pointers; a push into a full fifo is dropped and flagged
    if (pop) next_r.rptr = r.rptr + 11'h1;
    if (fifo_we) begin
      if (count == ptp_rew_pkg::FIFO_FULL_CNT) begin
        fifo_we = 1'b0;
        next_r.fifo_ovf = 1'b1;
      end else begin
        next_r.wptr = r.wptr + 11'h1;
      end
    end

    // register reads, answered the cycle after the strobe; unmapped reads give zero
    next_r.rdata = 32'h0;
    if (i_reg_rd) begin
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_MODE)) next_r.rdata = {28'h0, r.pmode[pi], r.domain[pi]};
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_EDLY)) next_r.rdata = r.edly[pi];
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_IDLY1)) next_r.rdata = r.idly1[pi];
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_IDLY2)) next_r.rdata = r.idly2[pi];
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_SMAC_LO)) next_r.rdata = r.smac_lo[pi];
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_SMAC_HI)) next_r.rdata = {16'h0, r.smac_hi[pi]};
      if (port_hit(i_reg_addr, ptp_rew_pkg::OFS_PORT_CFG)) begin
        next_r.rdata = {13'h0, r.port_dom[pi], r.ptp_en[pi], r.io_dly[pi]};
      end
      if (i_reg_addr[10] && i_reg_addr[1:0] == 2'h0) begin
        next_r.rdata = {16'h0, seq_table[i_reg_addr[9:2]]};
      end
      case (i_reg_addr)
        ptp_rew_pkg::OFS_CSUM_DIS: next_r.rdata = {21'h0, r.csum_dis};
        ptp_rew_pkg::OFS_CPU_MODE: next_r.rdata = {24'h0, r.cpu_mode[1], r.cpu_dom[1], r.cpu_mode[0], r.cpu_dom[0]};
        ptp_rew_pkg::OFS_RSRV: next_r.rdata = {21'h0, r.rsrv_sticky};
        ptp_rew_pkg::OFS_EVENTS: next_r.rdata = {21'h0, r.ovf_sticky};
        ptp_rew_pkg::OFS_PHY_PRED0: next_r.rdata = {16'h0, r.phy_pred[0]};
        ptp_rew_pkg::OFS_PHY_PRED1: next_r.rdata = {16'h0, r.phy_pred[1]};
        ptp_rew_pkg::OFS_PHASE: next_r.rdata = {21'h0, r.phase_en};
        ptp_rew_pkg::OFS_FIFO_CTRL: begin
          next_r.rdata = {13'h0, r.fifo_ovf, count != '0, head[ptp_rew_pkg::ENTRY_W-1 -: 5], 1'b0, count};
        end
        ptp_rew_pkg::OFS_FIFO_ENTRY: next_r.rdata = head[ptp_rew_pkg::STAMP_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
      r.state <= ptp_rew_pkg::ST_IDLE;
      r.ready <= 1'b1;
      r.out_csum_update <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (seq_we) seq_table[seq_widx] <= seq_wdata;
    if (fifo_we) fifo_mem[r.wptr[ptp_rew_pkg::PTR_W-2:0]] <= fifo_wdata;
  end

  assign o_reg_rdata = r.rdata;
  assign o_frm_ready = r.ready;
  assign o_out_valid = r.out_valid;
  assign o_out_tx_port = r.out_tx_port;
  assign o_out_ts_mode = r.out_ts_mode;
  assign o_out_delay = r.out_delay;
  assign o_out_cf_rx_time = r.out_cf_rx_time;
  assign o_out_seq_valid = r.out_seq_valid;
  assign o_out_seq_no = r.out_seq_no;
  assign o_out_dmac = r.out_dmac;
  assign o_out_smac = r.out_smac;
  assign o_out_csum_update = r.out_csum_update;
  assign o_out_domain = r.out_domain;
  assign o_out_port_mode = r.out_port_mode;
  assign o_port_io_delay = r.io_dly;
  assign o_port_ptp_en = r.ptp_en;
  assign o_port_domain = r.port_dom;
  assign o_phy_predict = r.phy_pred;
  assign o_phase_predict_en = r.phase_en;

  // checks
  logic [7:0] chk_seq_idx;
  always_ff @(posedge i_clk) begin
    chk_seq_idx <= i_frm_tstamp[7:0];
  end

  sequence s_take;
    i_frm_valid && o_frm_ready;
  endsequence
  sequence s_two_step;
    s_take ##0 i_frm_action[1:0] == ptp_rew_pkg::TS_TWO;
  endsequence
  sequence s_stall_then_ready;
    !o_frm_ready ##1 o_frm_ready;
  endsequence

  property p_ts_mode;
    @(posedge i_clk) disable iff (!i_resetn)
    s_take |=> o_out_valid && o_out_ts_mode == $past(i_frm_action[1:0]);
  endproperty
  a_ts_mode: assert property (p_ts_mode) else $error("timing mode not taken from action");

  property p_no_delay;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 i_frm_action[3:2] == ptp_rew_pkg::DLY_NONE) |=> o_out_delay == 32'h0;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("delay added when none selected");

  property p_seq_incr;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 i_frm_action[5:4] == ptp_rew_pkg::SEQ_UPD) |=>
      o_out_seq_valid && seq_table[chk_seq_idx] == o_out_seq_no + 16'h1;
  endproperty
  a_seq_incr: assert property (p_seq_incr) else $error("sequence entry not incremented");

  property p_cf_rx;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 i_frm_action[5] && i_frm_action[1:0] == ptp_rew_pkg::TS_ONE) |=> o_out_cf_rx_time;
  endproperty
  a_cf_rx: assert property (p_cf_rx) else $error("reception-time correction not flagged");

  property p_dmac_copy;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 i_frm_action[6]) |=> o_out_dmac == $past(i_frm_smac);
  endproperty
  a_dmac_copy: assert property (p_dmac_copy) else $error("destination not copied from source");

  property p_smac_keep;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 !i_frm_action[7]) |=> o_out_smac == $past(i_frm_smac);
  endproperty
  a_smac_keep: assert property (p_smac_keep) else $error("source replaced without request");

  property p_rsrv;
    @(posedge i_clk) disable iff (!i_resetn)
    (s_take ##0 i_frm_rsrv_nonzero && i_frm_rx_port < ptp_rew_pkg::PORT_CPU) |=>
      r.rsrv_sticky[$past(i_frm_rx_port)];
  endproperty
  a_rsrv: assert property (p_rsrv) else $error("reserved-field sticky not set");

  property p_ovf;
    @(posedge i_clk) disable iff (!i_resetn)
    i_cf_overflow != '0 |=> (r.ovf_sticky & $past(i_cf_overflow)) == $past(i_cf_overflow);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow event not sticky");

  property p_two_step;
    @(posedge i_clk) disable iff (!i_resetn)
    s_two_step |=> s_stall_then_ready;
  endproperty
  a_two_step: assert property (p_two_step) else $error("two-step push did not take two cycles");
endmodule
`default_nettype wire

// File: dv/frame_source.sv
// classifier stage model that hands action words to the decoder
`timescale 1ns/1ps
`default_nettype none
module frame_source (
  // clock and decoder ready
  input wire logic i_clk,
  input wire logic i_frm_ready,
  // frame action out
  output logic o_frm_valid,
  output logic [7:0] o_frm_action,
  output logic [31:0] o_frm_tstamp,
  output logic [31:0] o_frm_egress_stamp,
  output logic [3:0] o_frm_rx_port,
  output logic [3:0] o_frm_tx_port,
  output logic [47:0] o_frm_smac,
  output logic [47:0] o_frm_dmac,
  output logic o_frm_rsrv_nonzero
);
  initial begin
    {o_frm_valid, o_frm_action, o_frm_tstamp, o_frm_egress_stamp} = '0;
    {o_frm_rx_port, o_frm_tx_port, o_frm_smac, o_frm_dmac, o_frm_rsrv_nonzero} = '0;
  end
  // holds the frame until the decoder takes it, so a stall after a two-step frame is honoured
  task automatic send(input logic [7:0] act, input logic [31:0] ts, input logic [3:0] tx, input logic rsv);
    o_frm_valid <= 1'b1;
    o_frm_action <= act;
    o_frm_tstamp <= ts;
    o_frm_egress_stamp <= ~ts;
    // table index is only trusted when the frame is injected
    o_frm_rx_port <= (act[5:4] == ptp_rew_pkg::SEQ_UPD) ? ptp_rew_pkg::PORT_CPU : 4'h4;
    o_frm_tx_port <= tx;
    o_frm_smac <= 48'h0A0B0C0D0E0F;
    o_frm_dmac <= 48'h111111111111;
    o_frm_rsrv_nonzero <= rsv;
    do @(posedge i_clk); while (!i_frm_ready);
    o_frm_valid <= 1'b0;
    o_frm_action <= ~act;
    o_frm_tstamp <= ~ts;
  endtask
endmodule
`default_nettype wire

// File: dv/test_ptp_rewriter_action_decode.sv
// self-checking bench for the timing action decoder
`timescale 1ns/1ps
`default_nettype none
module test_ptp_rewriter_action_decode;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic [31:0] i_reg_wdata = 32'h0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [10:0] i_cf_overflow = 11'h000;
  wire logic fv, frs;
  wire logic [7:0] fa;
  wire logic [31:0] fts, fes;
  wire logic [3:0] frx, ftx;
  wire logic [47:0] fsm, fdm;
  logic [31:0] o_reg_rdata, o_out_delay;
  logic o_frm_ready, o_out_valid, o_out_cf_rx_time, o_out_seq_valid, o_out_csum_update;
  logic [1:0] o_out_ts_mode, o_out_domain, o_out_port_mode;
  logic [15:0] o_out_seq_no;
  logic [47:0] o_out_dmac, o_out_smac;
  logic [3:0] otx;
  logic [10:0] pen, phe;
  logic [10:0][15:0] pio;
  logic [10:0][1:0] pdom;
  logic [1:0][15:0] ppr;
  logic [31:0] dly_exp [4] = '{32'h0, 32'h11, 32'h22, 32'h33};
  int err_count = 0;
  int checks = 0;
  always #12.5 i_clk = ~i_clk;
  frame_source i_frame_source (.i_clk(i_clk), .i_frm_ready(o_frm_ready), .o_frm_valid(fv), .o_frm_action(fa),
    .o_frm_tstamp(fts),
    .o_frm_egress_stamp(fes), .o_frm_rx_port(frx), .o_frm_tx_port(ftx), .o_frm_smac(fsm), .o_frm_dmac(fdm),
    .o_frm_rsrv_nonzero(frs));
  ptp_rewriter_action_decode i_ptp_rewriter_action_decode (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_frm_valid(fv), .o_frm_ready(o_frm_ready), .i_frm_action(fa),
    .i_frm_tstamp(fts), .i_frm_egress_stamp(fes), .i_frm_rx_port(frx), .i_frm_tx_port(ftx), .i_frm_smac(fsm),
    .i_frm_dmac(fdm), .i_frm_rsrv_nonzero(frs), .o_out_valid(o_out_valid), .o_out_tx_port(otx),
    .o_out_ts_mode(o_out_ts_mode), .o_out_delay(o_out_delay), .o_out_cf_rx_time(o_out_cf_rx_time),
    .o_out_seq_valid(o_out_seq_valid), .o_out_seq_no(o_out_seq_no), .o_out_dmac(o_out_dmac),
    .o_out_smac(o_out_smac), .o_out_csum_update(o_out_csum_update), .o_out_domain(o_out_domain),
    .o_out_port_mode(o_out_port_mode), .i_cf_overflow(i_cf_overflow), .o_port_io_delay(pio), .o_port_ptp_en(pen),
    .o_port_domain(pdom), .o_phy_predict(ppr), .o_phase_predict_en(phe));
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // sampled at the edge that ends the data cycle, before the zero lands
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    chk("rdata", o_reg_rdata, exp);
  endtask
  task automatic fr(input logic [7:0] act, input logic [31:0] ts, input logic [3:0] tx, input logic rsv);
    i_frame_source.send(act, ts, tx, rsv);
    @(posedge i_clk);
    chk("out_valid", o_out_valid, 1);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    chk("csum_update", o_out_csum_update, 1);
    chk("port_domain", pdom, 22'h0);
    fr(8'h02, 32'h1234, 4'h3, 1'b0);
    chk("ready", o_frm_ready, 0);
    rd(ptp_rew_pkg::OFS_FIFO_CTRL, 32'h33002);
    rd(ptp_rew_pkg::OFS_FIFO_ENTRY, 32'hFFFFEDCB);
    wr(ptp_rew_pkg::OFS_FIFO_CTRL, 32'h1);
    rd(ptp_rew_pkg::OFS_FIFO_CTRL, 32'h24001);
    rd(ptp_rew_pkg::OFS_FIFO_ENTRY, 32'h1234);
    wr(ptp_rew_pkg::OFS_EDLY + 12'h00C, 32'h11);
    wr(ptp_rew_pkg::OFS_IDLY1 + 12'h010, 32'h22);
    wr(ptp_rew_pkg::OFS_IDLY2 + 12'h010, 32'h33);
    rd(ptp_rew_pkg::OFS_IDLY2 + 12'h010, 32'h33);
    for (int i = 0; i < 4; i++) begin
      fr({4'h0, i[1:0], i[1:0]}, 32'h0, 4'h3, 1'b0);
      chk("ts_mode", o_out_ts_mode, i[1:0]);
      chk("delay", o_out_delay, dly_exp[i]);
      @(posedge i_clk);
    end
    wr(ptp_rew_pkg::OFS_SEQ + 12'h014, 32'hFF);
    fr(8'h10, 32'h105, 4'h3, 1'b0);
    chk("seq_valid", o_out_seq_valid, 1);
    chk("seq_no", o_out_seq_no, 16'h00FF);
    rd(ptp_rew_pkg::OFS_SEQ + 12'h014, 32'h100);
    fr(8'h21, 32'h0, 4'h3, 1'b0);
    chk("cf_rx_time", o_out_cf_rx_time, 1);
    wr(ptp_rew_pkg::OFS_MODE + 12'h00C, 32'hE);
    wr(ptp_rew_pkg::OFS_CSUM_DIS, 32'h8);
    wr(ptp_rew_pkg::OFS_SMAC_LO + 12'h00C, 32'h89ABCDEF);
    wr(ptp_rew_pkg::OFS_SMAC_HI + 12'h00C, 32'h4567);
    fr(8'hC0, 32'h0, 4'h3, 1'b0);
    chk("dmac", o_out_dmac, 48'h0A0B0C0D0E0F);
    chk("smac", o_out_smac, 48'h456789ABCDEF);
    chk("domain", o_out_domain, 2'h2);
    chk("port_mode", o_out_port_mode, 2'h3);
    chk("csum_update", o_out_csum_update, 0);
    wr(ptp_rew_pkg::OFS_CPU_MODE, 32'h79);
    fr(8'h00, 32'h0, ptp_rew_pkg::PORT_CPU, 1'b1);
    chk("domain", o_out_domain, 2'h1);
    chk("port_mode", o_out_port_mode, 2'h2);
    chk("tx_port", otx, ptp_rew_pkg::PORT_CPU);
    fr(8'h00, 32'h0, ptp_rew_pkg::PORT_VD, 1'b0);
    chk("domain", o_out_domain, 2'h3);
    chk("port_mode", o_out_port_mode, 2'h1);
    rd(ptp_rew_pkg::OFS_RSRV, 32'h10);
    wr(ptp_rew_pkg::OFS_RSRV, 32'h10);
    rd(ptp_rew_pkg::OFS_RSRV, 32'h0);
    i_cf_overflow <= 11'h004;
    @(posedge i_clk);
    i_cf_overflow <= 11'h000;
    rd(ptp_rew_pkg::OFS_EVENTS, 32'h4);
    rd(12'h300, 32'h0);
    wr(ptp_rew_pkg::OFS_PORT_CFG + 12'h008, 32'h5ABCD);
    chk("io_delay", pio[2], 16'hABCD);
    chk("ptp_en", pen, 11'h004);
    chk("port_domain", pdom[2], 2'h2);
    wr(ptp_rew_pkg::OFS_PHY_PRED1, 32'h1357);
    chk("phy_predict", ppr[1], 16'h1357);
    wr(ptp_rew_pkg::OFS_PHASE, 32'h401);
    chk("phase_en", phe, 11'h401);
    complete_run();
  end
endmodule
`default_nettype wire
